// ===== rtl/sld_consts.vh
// sld_consts.vh: constants for the serial led display driver
// assumes inclusion by bare name from design files under rtl/
`ifndef SLD_CONSTS_VH
`define SLD_CONSTS_VH
// frame layout
`define SLD_FRAME_W 16
`define SLD_ADDR_HI 11
`define SLD_ADDR_LO 8
`define SLD_DATA_HI 7
`define SLD_DATA_LO 0
// register addresses (4-bit address field)
`define SLD_ADDR_NOOP 4'h0
`define SLD_ADDR_DIG0 4'h1
`define SLD_ADDR_DIG7 4'h8
`define SLD_ADDR_DECODE 4'h9
`define SLD_ADDR_BRIGHT 4'hA
`define SLD_ADDR_PWRDN 4'hC
`define SLD_ADDR_TEST 4'hF
// reset values
`define SLD_RST_BYTE 8'h00
`define SLD_RST_NIB 4'h0
// timing
`define SLD_CLK_MHZ 100
`define SLD_WAKE_US 250
`define SLD_SCAN_HZ 800
`define SLD_PWM_STEPS 32
// segment bit positions in a raw byte: dp,a,b,c,d,e,f,g
`define SLD_DP_BIT 7
`define SLD_SEG_OFF 8'h00
`define SLD_DIG_OFF 8'hFF
`endif

// ===== rtl/sld_fifo.v
// sld_fifo.v: small synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-low reset
`timescale 1ns/10ps
`include "sld_consts.vh"
module sld_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  input wire ref_clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // storage array
  reg [AW-1:0] wr_ptr_r; // write index
  reg [AW-1:0] rd_ptr_r; // read index
  reg [AW:0] count_r; // words held
  wire do_wr;
  wire do_rd;
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  // pointer and count update; full and empty come from the count only
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        mem_r[wr_ptr_r] <= in_data;
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (do_rd)
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (do_wr && !do_rd)
        count_r <= count_r + 1'b1;
      else if (do_rd && !do_wr)
        count_r <= count_r - 1'b1;
    end
  end
endmodule // sld_fifo

// ===== rtl/sld_top.v
// sld_top.v: serially programmed eight-digit seven-segment display driver
// holds the serial front end, the register file, scan, pwm and font decode
// assumes ref_clk at 100 MHz; serial pins arrive asynchronously from a host
// assumes the digit lines sink current and the segment lines source it
`timescale 1ns/10ps
`include "sld_consts.vh"
module sld_top #(
  parameter WAKE_CYC = `SLD_WAKE_US * `SLD_CLK_MHZ,
  parameter SLOT_CYC = (`SLD_CLK_MHZ * 1000000) / (`SLD_SCAN_HZ * 8),
  parameter FIFO_DEPTH = 4
)
(
  input wire ref_clk,
  input wire rst_n,
  input wire serial_clk,
  input wire serial_din,
  input wire load_strobe,
  output reg cascade_out,
  output reg [7:0] segment_drive,
  output reg [7:0] digit_drive
);
  // counter widths; sixteen bits holds the default slot and wake counts
  localparam SLOT_W = 16;
  localparam WAKE_W = 16;
  localparam PH_W = 5;
  // two-stage synchronisers for the three host pins; the third stage of the
  // clock and strobe lines only serves edge detection
  reg sclk_s1_r; // serial clock, first stage, may go metastable
  reg sclk_s2_r; // serial clock, settled
  reg sclk_s3_r; // serial clock, one cycle older
  reg din_s1_r; // serial data, first stage
  reg din_s2_r; // serial data, settled
  reg ld_s1_r; // strobe, first stage
  reg ld_s2_r; // strobe, settled
  reg ld_s3_r; // strobe, one cycle older
  // edge strobes, each high for one clock
  wire sclk_rise;
  wire sclk_fall;
  wire ld_rise;
  // reset values match the idle level of the pins, so no false edge follows
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
      ld_s1_r <= 1'b0;
      ld_s2_r <= 1'b0;
      ld_s3_r <= 1'b0;
    end
    else
    begin
      sclk_s1_r <= serial_clk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      din_s1_r <= serial_din;
      din_s2_r <= din_s1_r;
      ld_s1_r <= load_strobe;
      ld_s2_r <= ld_s1_r;
      ld_s3_r <= ld_s2_r;
    end
  end
  // edge detection only looks at second and third stages, so a first stage
  // that is still settling never reaches the logic
  assign sclk_rise = sclk_s2_r && !sclk_s3_r;
  assign sclk_fall = !sclk_s2_r && sclk_s3_r;
  assign ld_rise = ld_s2_r && !ld_s3_r;
  // serial shift register and cascade output
  // a bit enters on each detected rise; the top bit moves on to the cascade
  // pin, which repeats each bit sixteen and a half serial clocks later
  reg [`SLD_FRAME_W-1:0] shift_r; // msb first frame
  reg last_bit_r; // msb seen on rise, shown on next fall
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      shift_r <= {`SLD_FRAME_W{1'b0}};
      last_bit_r <= 1'b0;
      cascade_out <= 1'b0; // driven from reset on, never floats
    end
    else
    begin
      if (sclk_rise)
      begin
        shift_r <= {shift_r[`SLD_FRAME_W-2:0], din_s2_r};
        last_bit_r <= shift_r[`SLD_FRAME_W-1];
      end
      // bit leaves sixteen rises later, half a cycle on at the fall
      if (sclk_fall)
        cascade_out <= last_bit_r;
    end
  end
  // the strobe edge pushes the low twelve frame bits into the fifo; the
  // register side pops a word every clock, so the fifo never fills and a
  // strobe could only be lost if strobes came faster than one per clock
  wire fifo_in_ready; // space flag, unused: the drain rate keeps it high
  wire fifo_out_valid;
  wire [11:0] fifo_out_data;
  reg fifo_out_ready_r;
  // width follows the frame layout, depth the buffering choice
  sld_fifo #(
    .WIDTH(12),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(ld_rise),
    .in_ready(fifo_in_ready),
    .in_data(shift_r[`SLD_ADDR_HI:`SLD_DATA_LO]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready_r),
    .out_data(fifo_out_data)
  );
  // fields of the word leaving the fifo
  wire [3:0] wr_addr;
  wire [7:0] wr_data;
  wire wr_en;
  assign wr_addr = fifo_out_data[`SLD_ADDR_HI:`SLD_ADDR_LO];
  assign wr_data = fifo_out_data[`SLD_DATA_HI:`SLD_DATA_LO];
  assign wr_en = fifo_out_valid && fifo_out_ready_r;
  // register file; control registers live here, digit bytes further down
  // the fifo drains one word per clock, so strobes never back up behind it
  reg [7:0] decode_select_r; // per-digit font decode enable
  reg [3:0] brightness_level_r; // pwm step
  reg normal_op_r; // 0 = shutdown
  reg test_on_r; // display test, all segments lit
  reg [WAKE_W-1:0] wake_cnt_r; // delay when leaving shutdown
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fifo_out_ready_r <= 1'b0;
      decode_select_r <= `SLD_RST_BYTE;
      brightness_level_r <= `SLD_RST_NIB;
      normal_op_r <= 1'b0;
      test_on_r <= 1'b0;
      wake_cnt_r <= {WAKE_W{1'b0}};
    end
    else
    begin
      fifo_out_ready_r <= 1'b1;
      // wake count runs down to zero and stays there
      if (wake_cnt_r != {WAKE_W{1'b0}})
        wake_cnt_r <= wake_cnt_r - 1'b1;
      // writes go ahead in any mode
      if (wr_en)
      begin
        if (wr_addr == `SLD_ADDR_DECODE)
          decode_select_r <= wr_data;
        else if (wr_addr == `SLD_ADDR_BRIGHT)
          brightness_level_r <= wr_data[3:0];
        else if (wr_addr == `SLD_ADDR_PWRDN)
        begin
          normal_op_r <= wr_data[0];
          // only a shutdown-to-normal change restarts the wake count; a repeated
          // normal write leaves the display running instead of blanking it again
          if (wr_data[0] && !normal_op_r)
            wake_cnt_r <= WAKE_CYC[WAKE_W-1:0];
        end
        else if (wr_addr == `SLD_ADDR_TEST)
          test_on_r <= wr_data[0];
        // digit addresses are taken below; other addresses change nothing
      end
    end
  end
  // digit memory, one byte of flip-flops per entry; each entry sees only its
  // own address, so writing one digit cannot disturb another
  wire [7:0] digit_mem_w [0:7]; // digit data as read by the scan
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_dig
      localparam integer DIG_ADDR_I = `SLD_ADDR_DIG0 + g; // this entry's address
      localparam [3:0] DIG_ADDR = DIG_ADDR_I[3:0];
      reg [7:0] dig_r; // stored byte
      always @(posedge ref_clk)
      begin
        if (!rst_n)
          dig_r <= `SLD_RST_BYTE;
        else if (wr_en && wr_addr == DIG_ADDR)
          dig_r <= wr_data;
      end
      assign digit_mem_w[g] = dig_r;
    end
  endgenerate
  // scan and pwm timing; 32 pwm phases per digit slot
  // eight slots make one full scan of the display
  reg [SLOT_W-1:0] slot_cnt_r; // cycles within a pwm phase
  reg [PH_W-1:0] phase_r; // pwm phase 0..31
  reg [2:0] scan_r; // active digit
  // phase length rounds down; a slot below 32 cycles would leave it zero,
  // so the slot length should be a multiple of the phase count
  localparam integer PH_CYC_I = SLOT_CYC / `SLD_PWM_STEPS; // cycles per pwm phase
  localparam [SLOT_W-1:0] PH_CYC = PH_CYC_I[SLOT_W-1:0];
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      slot_cnt_r <= {SLOT_W{1'b0}};
      phase_r <= {PH_W{1'b0}};
      scan_r <= 3'h0;
    end
    else if (slot_cnt_r == PH_CYC - 1'b1)
    begin
      slot_cnt_r <= {SLOT_W{1'b0}};
      phase_r <= phase_r + 1'b1;
      // the slot ends as the phase counter wraps
      if (phase_r == {PH_W{1'b1}})
        scan_r <= scan_r + 3'h1;
    end
    else
      slot_cnt_r <= slot_cnt_r + 1'b1;
  end
  // font decoder for the low nibble, a..g in bits 6..0
  // a..g order matches raw mode, so decode only replaces bits 6..0
  function [6:0] font;
    input [3:0] code;
    begin
      case (code)
        4'h0: font = 7'h7E;
        4'h1: font = 7'h30;
        4'h2: font = 7'h6D;
        4'h3: font = 7'h79;
        4'h4: font = 7'h33;
        4'h5: font = 7'h5B;
        4'h6: font = 7'h5F;
        4'h7: font = 7'h70;
        4'h8: font = 7'h7F;
        4'h9: font = 7'h7B;
        4'hA: font = 7'h01;
        4'hB: font = 7'h4F;
        4'hC: font = 7'h37;
        4'hD: font = 7'h0E;
        4'hE: font = 7'h67;
        default: font = 7'h00;
      endcase
    end
  endfunction
  // segment pattern and on-time for the active digit
  wire [7:0] cur_byte;
  wire [7:0] cur_seg;
  wire pwm_on;
  wire lit;
  assign cur_byte = digit_mem_w[scan_r];
  // bit seven stays the decimal point in either mode
  assign cur_seg = decode_select_r[scan_r] ?
    {cur_byte[`SLD_DP_BIT], font(cur_byte[3:0])} : cur_byte;
  // on while phase <= 2n, i.e. 2n+1 of 32 phases
  assign pwm_on = ({1'b0, phase_r} <= {1'b0, brightness_level_r, 1'b0});
  // test beats shutdown; wake delay keeps the display dark meanwhile
  // display test ignores the wake delay as well as shutdown
  assign lit = test_on_r || (normal_op_r && wake_cnt_r == {WAKE_W{1'b0}});
  // registered drivers; digit lines sink, so low selects a digit
  // both drivers change on the same edge, so a digit never shows its
  // neighbour's segments for a cycle
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      segment_drive <= `SLD_SEG_OFF;
      digit_drive <= `SLD_DIG_OFF;
    end
    // dark display or off phase: segments low, digits high
    else if (!lit || !pwm_on)
    begin
      segment_drive <= `SLD_SEG_OFF;
      digit_drive <= `SLD_DIG_OFF;
    end
    else
    begin
      segment_drive <= test_on_r ? 8'hFF : cur_seg;
      digit_drive <= ~(8'h01 << scan_r);
    end
  end
endmodule // sld_top

// ===== verification/sld_top_chk.sv
// sld_top_chk.sv: port checker for sld_top
// assumes it is bound to sld_top and sees only its ports
`timescale 1ns/10ps
module sld_top_chk #(
  parameter WAKE_CYC = 25000
)
(
  input wire ref_clk,
  input wire rst_n,
  input wire serial_clk,
  input wire serial_din,
  input wire load_strobe,
  input wire cascade_out,
  input wire [7:0] segment_drive,
  input wire [7:0] digit_drive
);
  reg seen_r; // a strobe came since reset
  reg [31:0] age_r; // cycles since first strobe
  // age saturates so a long run never wraps it back under the wake time
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      seen_r <= 1'b0;
      age_r <= 32'h0;
    end
    else
    begin
      seen_r <= seen_r | load_strobe;
      age_r <= (seen_r && age_r < 32'hFFFF) ? age_r + 32'h1 : age_r;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // serial clock idle low or held high long enough for any edge to settle
  sequence s_low; !serial_clk [*8]; endsequence
  sequence s_high; serial_clk [*6]; endsequence
  property p_rst_blank;
    $past(rst_n) == 1'b0 |-> digit_drive == 8'hFF && segment_drive == 8'h00;
  endproperty
  a_rst_blank: assert property (p_rst_blank) else $error("display lit after reset");
  property p_rst_casc;
    $past(rst_n) == 1'b0 |-> cascade_out == 1'b0;
  endproperty
  a_rst_casc: assert property (p_rst_casc) else $error("cascade set after reset");
  property p_unprog;
    !seen_r |-> digit_drive == 8'hFF && segment_drive == 8'h00;
  endproperty
  a_unprog: assert property (p_unprog) else $error("display lit before any frame");
  property p_wake;
    digit_drive != 8'hFF |-> age_r >= WAKE_CYC;
  endproperty
  a_wake: assert property (p_wake) else $error("display lit before wake time");
  property p_one_digit;
    $countones(~digit_drive) <= 1;
  endproperty
  a_one_digit: assert property (p_one_digit) else $error("two digits selected");
  property p_casc_fall;
    $changed(cascade_out) |-> $past(serial_clk) == 1'b0;
  endproperty
  a_casc_fall: assert property (p_casc_fall) else $error("cascade moved off a fall");
  property p_casc_high;
    s_high |=> $stable(cascade_out);
  endproperty
  a_casc_high: assert property (p_casc_high) else $error("cascade moved while clock high");
  property p_casc_idle;
    s_low |=> $stable(cascade_out);
  endproperty
  a_casc_idle: assert property (p_casc_idle) else $error("cascade moved while idle");
endmodule // sld_top_chk

bind sld_top sld_top_chk #(.WAKE_CYC(WAKE_CYC)) sld_top_chk_inst (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .serial_clk(serial_clk),
  .serial_din(serial_din),
  .load_strobe(load_strobe),
  .cascade_out(cascade_out),
  .segment_drive(segment_drive),
  .digit_drive(digit_drive)
);

// ===== verification/sld_host_model.sv
// sld_host_model.sv: host that writes frames over the serial pins
// assumes a 100 MHz ref_clk; serial clock period is 16 ref_clk cycles
`timescale 1ns/10ps
module sld_host_model (
  input wire ref_clk,
  input wire cascade_out,
  output logic serial_clk,
  output logic serial_din,
  output logic load_strobe,
  output logic [15:0] cascade_seen
);
  initial
  begin
    serial_clk = 1'b0;
    serial_din = 1'b0;
    load_strobe = 1'b0;
    cascade_seen = 16'h0000;
  end
  // one frame, msb first; cascade sampled late in each low half
  task automatic send_frame(input logic [15:0] frame);
    for (int i = 15; i >= 0; i--)
    begin
      serial_din = frame[i];
      repeat (8) @(negedge ref_clk);
      cascade_seen = {cascade_seen[14:0], cascade_out};
      serial_clk = 1'b1;
      repeat (8) @(negedge ref_clk);
      serial_clk = 1'b0;
    end
    // data no longer valid, so show the inverse rather than a stale bit
    serial_din = ~frame[0];
    load_strobe = 1'b1;
    repeat (8) @(negedge ref_clk);
    load_strobe = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule // sld_host_model

// ===== verification/sld_top_tb_top.sv
// sld_top_tb_top.sv: self-checking bench for sld_top
// assumes the host model and the bound checker are compiled first
`timescale 1ns/10ps
module sld_top_tb_top;
  localparam int SLOT = 64; // short scan slot
  localparam int WAKE = 200; // short wake time
  logic ref_clk;
  logic rst_n = 1'b0;
  wire serial_clk;
  wire serial_din;
  wire load_strobe;
  wire cascade_out;
  wire [7:0] segment_drive;
  wire [7:0] digit_drive;
  wire [15:0] cascade_seen;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0; // watchdog count
  int lit; // lit cycles in a window
  logic [15:0] prev = 16'h0000; // last frame sent
  logic [6:0] font [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70,
    7'h7F, 7'h7B, 7'h01, 7'h4F, 7'h37, 7'h0E, 7'h67, 7'h00};
  logic [3:0] hole [4] = '{4'h0, 4'hB, 4'hD, 4'hE}; // unmapped addresses
  int lv [3] = '{0, 7, 15}; // brightness steps tried
  sld_top #(.WAKE_CYC(WAKE), .SLOT_CYC(SLOT), .FIFO_DEPTH(4)) sld_top_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .serial_clk(serial_clk),
    .serial_din(serial_din),
    .load_strobe(load_strobe),
    .cascade_out(cascade_out),
    .segment_drive(segment_drive),
    .digit_drive(digit_drive)
  );
  sld_host_model sld_host_model_inst (
    .ref_clk(ref_clk),
    .cascade_out(cascade_out),
    .serial_clk(serial_clk),
    .serial_din(serial_din),
    .load_strobe(load_strobe),
    .cascade_seen(cascade_seen)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic compare(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // the previous frame leaves on the cascade pin one bit behind
  task automatic send(input logic [15:0] f);
    sld_host_model_inst.send_frame(f);
    compare("cascade", {1'b0, cascade_seen[14:0]}, {1'b0, prev[15:1]});
    prev = f;
  endtask
  // wait for digit k to be selected, then sample its segments
  task automatic look(input int k, input logic [7:0] exp);
    for (int n = 0; n < 2000 && digit_drive !== ~(8'h01 << k); n++)
      @(negedge ref_clk);
    // both drivers come from one edge, so the selecting cycle shows its segments
    compare("segments", {8'h00, segment_drive}, {8'h00, exp});
  endtask
  task automatic count_lit(input int len);
    lit = 0;
    repeat (len)
    begin
      @(negedge ref_clk);
      lit += (digit_drive !== 8'hFF);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    compare("digits", {8'h00, digit_drive}, 16'h00FF);
    compare("segs", {8'h00, segment_drive}, 16'h0000);
    // program while still shut down; top nibble must be ignored
    send(16'hF1B6);
    send(16'h0A0F);
    send(16'h0C01);
    count_lit(WAKE - 40);
    compare("wake", 16'(lit), 16'h0000);
    look(0, 8'hB6);
    $display("test wake done");
    send(16'h0902);
    for (int c = 0; c < 16; c++)
    begin
      send({8'h02, c[0], 3'b101, c[3:0]});
      look(1, {c[0], font[c]});
    end
    look(0, 8'hB6);
    $display("test font done");
    foreach (hole[i])
      send({4'h0, hole[i], 8'h55});
    look(0, 8'hB6);
    look(1, 8'h80);
    $display("test unmapped done");
    send(16'h0C00);
    count_lit(8 * SLOT);
    compare("shutdown", 16'(lit), 16'h0000);
    // display test lights every segment even while shut down
    send(16'h0F01);
    look(3, 8'hFF);
    send(16'h0F00);
    count_lit(8 * SLOT);
    compare("test off", 16'(lit), 16'h0000);
    send(16'h0131);
    send(16'h0C01);
    count_lit(WAKE - 40);
    compare("rewake", 16'(lit), 16'h0000);
    look(0, 8'h31);
    look(1, 8'h80);
    $display("test shutdown done");
    foreach (lv[i])
    begin
      send({12'h0A0, lv[i][3:0]});
      repeat (SLOT) @(negedge ref_clk);
      count_lit(8 * SLOT);
      compare("duty", 16'(lit), 16'((2 * lv[i] + 1) * 8 * SLOT / 32));
    end
    $display("test brightness done");
    end_of_test;
  end
  // watchdog: a hang counts as a mismatch
  always @(negedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      bad_count++;
      end_of_test;
    end
  end
endmodule // sld_top_tb_top
